// ---- core/dual_stage_watchdog.sv ----
// Two-stage watchdog with Avalon-MM registers
//
// Behaviour
// - two stages, own time and action, sequential
// - code 0000 skips the stage, no action
// - code 0001 on expiry issues system reset
// - code 0101 is plain delay, stage one only
// - code 1000 drives time-out output only
// - codes 1001-1100 add reset, NMI, SMI, SCI
// - code 1101 delays then drives time-out output
// - time-out output rises when servicing stops
// - time-out output follows the selected stage
// - time-out output clears only by reset
module dual_stage_watchdog #(
    parameter int CNT_W = 32
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic timeout_event_output_out,
    output logic sys_reset_out,
    output logic nmi_out,
    output logic smi_out,
    output logic sci_out,
    output logic irq_out
);
    import wdog_pkg::*;

    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
        $error("dual_stage_watchdog: CNT_W must be 2 to 32");
    end

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    logic wr_fire;
    logic rd_fire;
    logic [7:0] word_addr;

    assign wr_fire = avs_write_in && !avs_waitrequest_out;
    assign rd_fire = avs_read_in && !avs_waitrequest_out;
    assign word_addr = {avs_address_in[7:2], 2'b00};

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] limit1;
    logic [31:0] limit2;
    logic [IRQ_W-1:0] irq_mask;
    logic enable;
    logic sel_two;
    logic [CODE_W-1:0] code1;
    logic [CODE_W-1:0] code2;
    logic kick;

    assign enable = ctrl[CTRL_EN_BIT];
    assign sel_two = ctrl[CTRL_SEL_BIT];
    assign code1 = ctrl[CTRL_CODE1_LSB +: CODE_W];
    assign code2 = ctrl[CTRL_CODE2_LSB +: CODE_W];
    assign kick = wr_fire && word_addr == REG_KICK;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ctrl <= CTRL_RST;
            limit1 <= LIMIT_RST;
            limit2 <= LIMIT_RST;
            irq_mask <= MASK_RST;
        end else if (wr_fire) begin
            case (word_addr)
                REG_CTRL: ctrl <= merge_be(ctrl, avs_writedata_in, avs_byteenable_in);
                REG_LIMIT1: limit1 <= merge_be(limit1, avs_writedata_in, avs_byteenable_in);
                REG_LIMIT2: limit2 <= merge_be(limit2, avs_writedata_in, avs_byteenable_in);
                REG_IRQ_MASK: irq_mask <= avs_byteenable_in[0] ?
                                          avs_writedata_in[IRQ_W-1:0] : irq_mask;
                default: ctrl <= ctrl;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Stage sequencer
    // ------------------------------------------------------------
    wd_state_t state;
    action_t act1;
    action_t act2;
    logic expired;
    logic [CNT_W-1:0] count;
    logic fire1;
    logic fire2;
    logic skip1;
    logic skip2;
    logic load;
    logic [CNT_W-1:0] load_val;
    logic [3:0] fire_vec;
    logic [3:0] pulses;

    assign act1 = decode_action(code1, 1'b1);
    assign act2 = decode_action(code2, 1'b0);

    always_comb begin
        fire1 = enable && state == ST_ONE && !kick && !act1.skip && expired;
        fire2 = enable && state == ST_TWO && !kick && !act2.skip && expired;
        skip1 = enable && state == ST_ONE && !kick && act1.skip;
        skip2 = enable && state == ST_TWO && !kick && act2.skip;
        load = 1'b0;
        load_val = limit1[CNT_W-1:0];
        if (enable && (kick || state == ST_IDLE)) begin
            load = 1'b1;
        end else if (fire1 || skip1) begin
            load = 1'b1;
            load_val = limit2[CNT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !enable) begin
            state <= ST_IDLE;
        end else if (kick) begin
            state <= ST_ONE;
        end else begin
            case (state)
                ST_IDLE: state <= ST_ONE;
                ST_ONE: state <= (fire1 || skip1) ? ST_TWO : ST_ONE;
                ST_TWO: state <= (fire2 || skip2) ? ST_DONE : ST_TWO;
                ST_DONE: state <= ST_DONE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    stage_timer #(
        .W(CNT_W)
    ) u_timer (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .load_in(load),
        .run_in(state == ST_ONE || state == ST_TWO),
        .value_in(load_val),
        .expired_out(expired),
        .count_out(count)
    );

    // ------------------------------------------------------------
    // Expiry actions
    // ------------------------------------------------------------
    always_comb begin
        fire_vec[0] = (fire1 && act1.rst) || (fire2 && act2.rst);
        fire_vec[1] = (fire1 && act1.nmi) || (fire2 && act2.nmi);
        fire_vec[2] = (fire1 && act1.smi) || (fire2 && act2.smi);
        fire_vec[3] = (fire1 && act1.sci) || (fire2 && act2.sci);
    end

    event_pulse #(
        .N(4),
        .LEN(PULSE_CYC)
    ) u_pulse (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .fire_in(fire_vec),
        .pulse_out(pulses)
    );

    assign sys_reset_out = pulses[0];
    assign nmi_out = pulses[1];
    assign smi_out = pulses[2];
    assign sci_out = pulses[3];

    logic out_hit;
    assign out_hit = (fire1 && act1.out && !sel_two) || (fire2 && act2.out && sel_two);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            timeout_event_output_out <= 1'b0;
        end else if (out_hit) begin
            timeout_event_output_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_set;
    logic irq_clr;

    assign irq_set = {out_hit, fire2 || skip2, fire1 || skip1};
    assign irq_clr = rd_fire && word_addr == REG_IRQ_STAT;

    // Clear only the bits already reported, so an event during the read survives
    logic [IRQ_W-1:0] irq_keep;
    assign irq_keep = irq_clr ? irq_stat & ~avs_readdata_out[IRQ_W-1:0] : irq_stat;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= irq_keep | irq_set;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |((irq_keep | irq_set) & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && avs_waitrequest_out) begin
            case (word_addr)
                REG_CTRL: avs_readdata_out <= ctrl;
                REG_LIMIT1: avs_readdata_out <= limit1;
                REG_LIMIT2: avs_readdata_out <= limit2;
                REG_STATUS: avs_readdata_out <= {27'h0, timeout_event_output_out, state};
                REG_IRQ_STAT: avs_readdata_out <= {29'h0, irq_stat};
                REG_IRQ_MASK: avs_readdata_out <= {29'h0, irq_mask};
                REG_COUNT: avs_readdata_out <= 32'(count);
                default: avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence stage_one_expires;
        fire1;
    endsequence

    sequence moves_to_two;
        state == ST_TWO && (count == $past(limit2[CNT_W-1:0]) || $past(limit2) == 32'h0);
    endsequence

    stage_order_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stage_one_expires |=> moves_to_two)
        else $error("stage one expiry did not start stage two");

    skip_off_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        enable && state == ST_ONE && code1 == CODE_OFF && !kick
        |=> state == ST_TWO && !$rose(timeout_event_output_out))
        else $error("disabled stage one was not skipped");

    reset_code_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire2 && code2 == CODE_RESET |=> sys_reset_out [*2])
        else $error("reset code gave no reset pulse");

    delay_two_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        enable && state == ST_TWO && code2 == CODE_DELAY && !kick |=> state == ST_DONE)
        else $error("delay code accepted in stage two");

    out_only_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire1 && code1 == CODE_OUT && !sel_two
        |=> timeout_event_output_out && !$rose(sys_reset_out) && !$rose(nmi_out)
            && !$rose(smi_out) && !$rose(sci_out))
        else $error("output-only code misbehaved");

    nmi_pair_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire2 && code2 == CODE_OUT_NMI && sel_two |=> nmi_out && timeout_event_output_out)
        else $error("NMI code did not drive both outputs");

    delay_out_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire1 && code1 == CODE_DELAY_OUT && !sel_two && !(fire_vec != 4'h0)
        |=> timeout_event_output_out && !$rose(sys_reset_out) && !$rose(nmi_out))
        else $error("delay with output took a corrective action");

    timeout_cause_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(timeout_event_output_out) |-> $past(fire1 || fire2))
        else $error("time-out output rose without an expiry");

    stage_select_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire1 && sel_two && !timeout_event_output_out
        |=> !timeout_event_output_out)
        else $error("time-out output followed the wrong stage");

    timeout_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        timeout_event_output_out |=> timeout_event_output_out)
        else $error("time-out output dropped without reset");

    kick_restart_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        kick && enable |=> state == ST_ONE && count == limit1[CNT_W-1:0]
            || limit1 == 32'h0)
        else $error("kick did not restart stage one");

    undefined_code_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        enable && state == ST_ONE && !kick && code1 inside {4'h2, 4'h3, 4'h4, 4'h6,
            4'h7, 4'hE, 4'hF} |=> state == ST_TWO && $stable(pulses))
        else $error("undefined code was not treated as disabled");

    reset_one_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire1 && code1 == CODE_RESET |=> sys_reset_out && !$rose(timeout_event_output_out))
        else $error("stage one reset code gave no reset pulse");

    delay_one_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire1 && code1 == CODE_DELAY |=> state == ST_TWO && !$rose(timeout_event_output_out)
            && !$rose(sys_reset_out) && !$rose(nmi_out) && !$rose(smi_out) && !$rose(sci_out))
        else $error("stage one delay took an action");

    reset_pair_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire2 && code2 == CODE_OUT_RST && sel_two
        |=> sys_reset_out && timeout_event_output_out)
        else $error("reset code did not drive both outputs");

    smi_pair_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire1 && code1 == CODE_OUT_SMI && !sel_two
        |=> smi_out && timeout_event_output_out)
        else $error("SMI code did not drive both outputs");

    sci_pair_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        fire1 && code1 == CODE_OUT_SCI && !sel_two
        |=> sci_out && timeout_event_output_out)
        else $error("SCI code did not drive both outputs");

    pulse_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(nmi_out) |-> nmi_out [*8])
        else $error("NMI pulse ended early");

    wait_pulse_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest stayed low for two cycles");

    irq_level_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (irq_stat & irq_mask) != '0 && !irq_clr |=> irq_out)
        else $error("unmasked status bit gave no interrupt");
endmodule : dual_stage_watchdog

// ---- core/wdog_pkg.sv ----
// Constants, types and decode functions of the two-stage watchdog
package wdog_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LIMIT1 = 8'h04;
    localparam logic [7:0] REG_LIMIT2 = 8'h08;
    localparam logic [7:0] REG_KICK = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_STAT = 8'h14;
    localparam logic [7:0] REG_IRQ_MASK = 8'h18;
    localparam logic [7:0] REG_COUNT = 8'h1C;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SEL_BIT = 1;
    localparam int CTRL_CODE1_LSB = 4;
    localparam int CTRL_CODE2_LSB = 8;
    localparam int CODE_W = 4;
    localparam int IRQ_W = 3;
    localparam int IRQ_STAGE1 = 0;
    localparam int IRQ_STAGE2 = 1;
    localparam int IRQ_TIMEOUT = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RST = 32'h0000_FFFF;
    localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
    // ------------------------------------------------------------
    // Action codes
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_OFF = 4'h0;
    localparam logic [3:0] CODE_RESET = 4'h1;
    localparam logic [3:0] CODE_DELAY = 4'h5;
    localparam logic [3:0] CODE_OUT = 4'h8;
    localparam logic [3:0] CODE_OUT_RST = 4'h9;
    localparam logic [3:0] CODE_OUT_NMI = 4'hA;
    localparam logic [3:0] CODE_OUT_SMI = 4'hB;
    localparam logic [3:0] CODE_OUT_SCI = 4'hC;
    localparam logic [3:0] CODE_DELAY_OUT = 4'hD;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int PULSE_NS = 160;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ONE = 4'b0010,
        ST_TWO = 4'b0100,
        ST_DONE = 4'b1000
    } wd_state_t;
    typedef struct packed {
        logic skip;
        logic out;
        logic rst;
        logic nmi;
        logic smi;
        logic sci;
    } action_t;
    // Expiry action of one stage; first is high for stage one
    function automatic action_t decode_action(input logic [3:0] code, input logic first);
        action_t a;
        a = '0;
        case (code)
            CODE_RESET: a.rst = 1'b1;
            CODE_DELAY: a.skip = !first;
            CODE_OUT: a.out = 1'b1;
            CODE_OUT_RST: a = '{skip: 1'b0, out: 1'b1, rst: 1'b1, nmi: 1'b0,
                                smi: 1'b0, sci: 1'b0};
            CODE_OUT_NMI: a = '{skip: 1'b0, out: 1'b1, rst: 1'b0, nmi: 1'b1,
                                smi: 1'b0, sci: 1'b0};
            CODE_OUT_SMI: a = '{skip: 1'b0, out: 1'b1, rst: 1'b0, nmi: 1'b0,
                                smi: 1'b1, sci: 1'b0};
            CODE_OUT_SCI: a = '{skip: 1'b0, out: 1'b1, rst: 1'b0, nmi: 1'b0,
                                smi: 1'b0, sci: 1'b1};
            CODE_DELAY_OUT: a.out = 1'b1;
            default: a.skip = 1'b1;
        endcase
        return a;
    endfunction : decode_action
    // Byte-lane merge of a write into a 32-bit register
    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be
endpackage : wdog_pkg

// ---- core/stage_timer.sv ----
// Down counter that times one watchdog stage
module stage_timer #(
    parameter int W = 32
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic run_in,
    input wire logic [W-1:0] value_in,
    output logic expired_out,
    output logic [W-1:0] count_out
);
    if (W < 2) begin : g_bad_width
        $error("stage_timer: W must be at least 2");
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            count_out <= '0;
        end else if (load_in) begin
            count_out <= (value_in == '0) ? W'(1) : value_in;
        end else if (run_in && count_out != '0) begin
            count_out <= count_out - W'(1);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            expired_out <= 1'b0;
        end else begin
            expired_out <= run_in && !load_in && count_out == W'(1);
        end
    end
endmodule : stage_timer

// ---- core/event_pulse.sv ----
// Stretches one-cycle events into fixed-length output pulses
module event_pulse #(
    parameter int N = 4,
    parameter int LEN = 16
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [N-1:0] fire_in,
    output logic [N-1:0] pulse_out
);
    localparam int CW = $clog2(LEN + 1);
    logic [CW-1:0] left [N];

    if (LEN < 1 || N < 1) begin : g_bad_size
        $error("event_pulse: N and LEN must be positive");
    end

    for (genvar g = 0; g < N; g++) begin : g_lane
        always_ff @(posedge clk_sys_in) begin
            if (rst_in) begin
                left[g] <= '0;
                pulse_out[g] <= 1'b0;
            end else if (fire_in[g]) begin
                left[g] <= CW'(LEN - 1);
                pulse_out[g] <= 1'b1;
            end else if (left[g] != '0) begin
                left[g] <= left[g] - CW'(1);
            end else begin
                pulse_out[g] <= 1'b0;
            end
        end
    end
endmodule : event_pulse

// ---- tb/sys_sink_model.sv ----
// Host reset and interrupt logic model: counts each action pulse it receives
module sys_sink_model (
    input wire logic clk_sys_in,
    input wire logic clear_in,
    input wire logic sys_reset_in,
    input wire logic nmi_in,
    input wire logic smi_in,
    input wire logic sci_in,
    output logic [15:0] cnt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] act;
    logic [3:0] prev;
    assign act = {sci_in, smi_in, nmi_in, sys_reset_in};
    // ------------------------------------------------------------
    // Pulse counters, one nibble per action line
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        prev <= act;
        for (int i = 0; i < 4; i++) begin
            if (clear_in) begin
                cnt_out[i*4 +: 4] <= 4'h0;
            end else if (act[i] && !prev[i]) begin
                cnt_out[i*4 +: 4] <= cnt_out[i*4 +: 4] + 4'h1;
            end
        end
    end
endmodule : sys_sink_model

// ---- tb/tb.sv ----
// Self-checking bench of the two-stage watchdog
module tb;
    import wdog_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 1'b0;
    logic rst = 1'b1;
    logic sink_clr = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] q;
    logic [32:0] note;
    logic [32:0] exp_q[$];
    logic [15:0] cnt;
    logic wait_req, tmo, sys_rst, nmi, smi, sci, irq;
    int mismatches = 0;
    int total_checks = 0;
    // Entries are {follow stage two, code two, code one}
    logic [8:0] tbl [19] = '{9'h000, 9'h001, 9'h003, 9'h005, 9'h008, 9'h009, 9'h00A,
        9'h00B, 9'h00C, 9'h00D, 9'h00F, 9'h1D5, 9'h190, 9'h108, 9'h050, 9'h1BA, 9'h0E0,
        9'h1A1, 9'h01B};
    dual_stage_watchdog #(.CNT_W(32)) u_dual_stage_watchdog (
        .clk_sys_in(clk_sys_in), .rst_in(rst), .avs_address_in(adr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
        .timeout_event_output_out(tmo), .sys_reset_out(sys_rst), .nmi_out(nmi),
        .smi_out(smi), .sci_out(sci), .irq_out(irq));
    sys_sink_model u_sys_sink_model (
        .clk_sys_in(clk_sys_in), .clear_in(sink_clr), .sys_reset_in(sys_rst),
        .nmi_in(nmi), .smi_in(smi), .sci_in(sci), .cnt_out(cnt));
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Expected expiry action: {out, sci, smi, nmi, reset}
    function automatic logic [4:0] act_of(input logic [3:0] c);
        case (c)
            4'h1: return 5'h01;
            4'h8, 4'hD: return 5'h10;
            4'h9: return 5'h11;
            4'hA: return 5'h12;
            4'hB: return 5'h14;
            4'hC: return 5'h18;
            default: return 5'h00;
        endcase
    endfunction : act_of
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // Avalon master: one access, read notes its expected data
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic c);
        int k;
        k = 0;
        if (!w) exp_q.push_back({c, d});
        adr <= a;
        wdata <= w ? d : $urandom;
        rd_en <= !w;
        wr_en <= w;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (wait_req !== 1'b0 && k < 100);
        if (k == 100) chk(32'h0, 32'h1);
        q = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk_sys_in);
    endtask : bus
    // Read monitor: oldest note against each finished read
    always @(posedge clk_sys_in) begin
        if (rd_en && wait_req === 1'b0 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            if (note[32]) chk(rdata, note[31:0]);
        end
    end
    task automatic do_reset(input int n);
        rst <= 1'b1;
        sink_clr <= 1'b1;
        repeat (n) @(posedge clk_sys_in);
        rst <= 1'b0;
        sink_clr <= 1'b0;
        @(posedge clk_sys_in);
        chk(32'(tmo), 32'h0);
    endtask : do_reset
    task automatic wait_done();
        int k;
        k = 0;
        q = 32'h0;
        while (q[3] !== 1'b1 && k < 200) begin
            bus(1'b0, REG_STATUS, 32'h0, 1'b0);
            k++;
        end
        if (k == 200) chk(32'h0, 32'h1);
    endtask : wait_done
    // One full two-stage run with the given codes and output stage
    task automatic run(input logic [8:0] t);
        logic [4:0] a1, a2;
        logic [15:0] ec;
        logic eo;
        a1 = act_of(t[3:0]);
        a2 = act_of(t[7:4]);
        eo = t[8] ? a2[4] : a1[4];
        for (int i = 0; i < 4; i++) ec[i*4 +: 4] = 4'(a1[i]) + 4'(a2[i]);
        do_reset(2);
        bus(1'b1, REG_LIMIT1, 32'd3 + $urandom % 10, 1'b0);
        bus(1'b1, REG_LIMIT2, 32'd3 + $urandom % 10, 1'b0);
        bus(1'b1, REG_CTRL, {20'h0, t[7:4], t[3:0], 2'b0, t[8], 1'b1}, 1'b0);
        wait_done();
        repeat (20) @(posedge clk_sys_in);
        chk(32'(cnt), 32'(ec));
        chk(32'(tmo), 32'(eo));
        bus(1'b0, REG_STATUS, {27'h0, eo, 4'h8}, 1'b1);
        bus(1'b1, REG_CTRL, 32'h0, 1'b0);
        chk(32'(tmo), 32'(eo));
    endtask : run
    initial begin
        void'($urandom(32'hdcde));
        do_reset(10);
        bus(1'b0, REG_CTRL, CTRL_RST, 1'b1);
        bus(1'b0, REG_LIMIT1, LIMIT_RST, 1'b1);
        bus(1'b0, REG_LIMIT2, LIMIT_RST, 1'b1);
        bus(1'b0, REG_IRQ_MASK, 32'(MASK_RST), 1'b1);
        bus(1'b1, REG_STATUS, 32'hFFFF_FFFF, 1'b0);
        bus(1'b0, REG_STATUS, 32'h1, 1'b1);
        bus(1'b0, 8'h20, 32'h0, 1'b1);
        for (int i = 0; i < 19; i++) run(tbl[i]);
        // Kicks hold off expiry, then servicing stops
        do_reset(2);
        bus(1'b1, REG_LIMIT1, 32'd20, 1'b0);
        bus(1'b1, REG_CTRL, 32'h81, 1'b0);
        repeat (6) begin
            repeat (2 + $urandom % 8) @(posedge clk_sys_in);
            bus(1'b1, REG_KICK, $urandom, 1'b0);
        end
        bus(1'b0, REG_STATUS, 32'h2, 1'b1);
        wait_done();
        bus(1'b0, REG_STATUS, 32'h18, 1'b1);
        // Interrupt: masked, unmasked, read-cleared
        do_reset(2);
        bus(1'b1, REG_LIMIT1, 32'd4, 1'b0);
        bus(1'b1, REG_CTRL, 32'h81, 1'b0);
        wait_done();
        repeat (4) @(posedge clk_sys_in);
        chk(32'(irq), 32'h0);
        bus(1'b1, REG_IRQ_MASK, 32'h4, 1'b0);
        @(posedge clk_sys_in);
        chk(32'(irq), 32'h1);
        bus(1'b0, REG_IRQ_STAT, 32'h7, 1'b1);
        chk(32'(irq), 32'h0);
        bus(1'b0, REG_IRQ_STAT, 32'h0, 1'b1);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        mismatches++;
        summarize();
    end
endmodule : tb
